// file: include/branch_store_if.sv
// Carrier between the fetch logic and the branch store memory
interface branch_store_if #(
  parameter int AW = 5,
  parameter int DW = 32
);
  logic          wr_en;    // Write one word
  logic [AW-1:0] wr_addr;  // Write word address
  logic [DW-1:0] wr_data;  // Write word
  logic [AW-1:0] rd_addr;  // Read word address
  logic [DW-1:0] rd_data;  // Registered read word

  modport owner (output wr_en, wr_addr, wr_data, rd_addr,
                 input rd_data);
  modport mem   (input wr_en, wr_addr, wr_data, rd_addr,
                 output rd_data);
endinterface

// file: include/flash_fetch_pkg.sv
// Constants and types for the flash fetch front end
package flash_fetch_pkg;

  // =========================================================
  // Sizes
  // =========================================================
  localparam int QUEUE_DEPTH  = 4;   // Queue words
  localparam int GEN_ENTRIES  = 4;   // General branch entries
  localparam int ALL_ENTRIES  = 5;   // General plus vector entry
  localparam int IRQ_ENTRY    = 4;   // Index of vector entry
  localparam int ENTRY_WORDS  = 4;   // Words kept per entry
  localparam int MEM_DEPTH    = 20;  // Entries times words
  localparam int MEM_AW       = 5;   // Store word address width
  localparam int DATA_W       = 32;  // Flash word width

  // =========================================================
  // Rates and address steps
  // =========================================================
  localparam int FLASH_MAX_MHZ = 96; // Highest sustained fetch rate
  localparam int CLK_MHZ       = 25; // System clock of this build
  localparam logic [31:0] WORD_STEP  = 32'h00000004; // One word
  localparam logic [31:0] BURST_SPAN = 32'h00000010; // Four words

  // =========================================================
  // Reset values and limits
  // =========================================================
  localparam logic [2:0]  CNT_RESET  = 3'h0;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [2:0]  QUEUE_FULL = 3'h4;
  localparam logic [1:0]  AGE_OLDEST = 2'h3;
  localparam logic [1:0]  LAST_WORD  = 2'h3;

  // =========================================================
  // Types
  // =========================================================
  typedef enum logic {MODE_QUEUE, MODE_STORE} fetch_mode_t;
  typedef enum logic [1:0] {FL_IDLE, FL_PREF, FL_LIT} flash_state_t;

endpackage

// file: logic/branch_store_mem.sv
// Word memory holding the instructions of the branch target store
module branch_store_mem #(
  parameter int DEPTH = 20,
  parameter int AW    = 5,
  parameter int DW    = 32
)(
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  branch_store_if.mem     port
);

  logic [DW-1:0] words [DEPTH];  // Stored instruction words
  logic [DW-1:0] next_rd_data;   // Word read this cycle

  // =========================================================
  // Read path
  // =========================================================
  // Selects the addressed word
  always_comb
  begin
    next_rd_data = words[port.rd_addr];
  end

  // Registers the read word
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      port.rd_data <= '0;
    else
      port.rd_data <= next_rd_data;
  end

  // =========================================================
  // Write path
  // =========================================================
  // Array needs no reset; entries carry valid bits
  always_ff @(posedge clk_sys_i)
  begin
    if (port.wr_en)
      words[port.wr_addr] <= port.wr_data;
  end

endmodule

// file: logic/flash_prefetch_branch_cache.sv
// Instruction fetch front end: look-ahead queue and branch store
module flash_prefetch_branch_cache #(
  // Address of the vector-read instruction; value is arbitrary
  parameter logic [31:0] IRQ_VEC_ADDR = 32'h00000040
)(
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        fetch_req_i,
  input  wire logic [31:0] fetch_addr_i,
  output logic             fetch_ack_o,
  output logic [31:0]      fetch_data_o,
  input  wire logic        lit_req_i,
  input  wire logic [31:0] lit_addr_i,
  output logic             lit_ack_o,
  output logic [31:0]      lit_data_o,
  output logic             flash_req_o,
  output logic [31:0]      flash_addr_o,
  input  wire logic        flash_ack_i,
  input  wire logic [31:0] flash_data_i
);

  // =========================================================
  // State
  // =========================================================
  flash_fetch_pkg::fetch_mode_t  mode, next_mode;     // Word source
  flash_fetch_pkg::flash_state_t fstate, next_fstate; // Flash use

  logic [31:0] q [4];            // Queue words
  logic [31:0] next_q [4];
  logic [1:0]  rp, next_rp;      // Queue read slot
  logic [1:0]  wp, next_wp;      // Queue write slot
  logic [2:0]  cnt, next_cnt;    // Queue fill
  logic [31:0] head, next_head;  // Address of queue front word
  logic [31:0] pf_addr, next_pf_addr; // Next prefetch address
  logic        drop, next_drop;  // Discard word in flight

  logic [31:0] str_addr, next_str_addr; // Next address from store
  logic [2:0]  str_ent, next_str_ent;   // Entry being replayed
  logic [1:0]  str_idx, next_str_idx;   // Word being replayed

  logic [31:0] tag [5];          // Branch target addresses
  logic [31:0] next_tag [5];
  logic [4:0]  vld, next_vld;    // Entry complete
  logic [1:0]  age [4];          // Recency, 0 newest
  logic [1:0]  next_age [4];

  logic        cap_act, next_cap_act; // Capturing a new entry
  logic [2:0]  cap_ent, next_cap_ent; // Entry being filled
  logic [1:0]  cap_idx, next_cap_idx; // Word being filled

  logic        src_store, next_src_store; // Answer from store
  logic [31:0] qdata, next_qdata;         // Answer from queue
  logic        next_fetch_ack;
  logic        next_lit_ack;
  logic [31:0] next_lit_data;
  logic        next_flash_req;
  logic [31:0] next_flash_addr;

  // =========================================================
  // Lookup
  // =========================================================
  logic [4:0]  hit_vec;    // Per entry match
  logic        hit_any;    // Any match
  logic [2:0]  hit_ent;    // Matching entry
  logic [2:0]  victim;     // Entry to refill on a miss
  logic        touch_en;   // Update recency
  logic [1:0]  touch_ent;  // General entry just taken

  branch_store_if #(
    .AW (flash_fetch_pkg::MEM_AW),
    .DW (flash_fetch_pkg::DATA_W)
  ) store_bus ();

  branch_store_mem #(
    .DEPTH (flash_fetch_pkg::MEM_DEPTH),
    .AW    (flash_fetch_pkg::MEM_AW),
    .DW    (flash_fetch_pkg::DATA_W)
  ) u_store (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .port      (store_bus.mem)
  );

  // Compares every entry at once, vector entry included
  for (genvar e = 0; e < flash_fetch_pkg::ALL_ENTRIES; e++)
  begin : g_cmp
    assign hit_vec[e] = vld[e] && (tag[e] == fetch_addr_i);
  end

  // Recency update of the general entries
  for (genvar i = 0; i < flash_fetch_pkg::GEN_ENTRIES; i++)
  begin : g_age
    assign next_age[i] = !touch_en ? age[i] :
                         (touch_ent == 2'(i)) ? 2'h0 :
                         (age[i] < age[touch_ent]) ? 2'(age[i] + 2'h1) :
                         age[i];
  end

  // Encodes the hit and picks the refill entry
  always_comb
  begin
    hit_any = |hit_vec;
    hit_ent = 3'h0;
    for (int e = 0; e < flash_fetch_pkg::ALL_ENTRIES; e++)
      if (hit_vec[e])
        hit_ent = 3'(e);
    victim = 3'h0;
    for (int i = 0; i < flash_fetch_pkg::GEN_ENTRIES; i++)
      if (age[i] == flash_fetch_pkg::AGE_OLDEST)
        victim = 3'(i);
    for (int i = flash_fetch_pkg::GEN_ENTRIES - 1; i >= 0; i--)
      if (!vld[i])
        victim = 3'(i); // Free entry first
    if (fetch_addr_i == IRQ_VEC_ADDR)
      victim = 3'(flash_fetch_pkg::IRQ_ENTRY);
  end

  // =========================================================
  // Next state
  // =========================================================
  logic [31:0] expect_addr; // Sequential address the core should ask
  logic        take;        // Core request taken this cycle
  logic        push;        // Word enters queue
  logic        pop;         // Word leaves queue
  logic        flush;       // Queue restarts
  logic [31:0] base;        // Restart address
  logic        free;        // Flash can take a request

  always_comb
  begin
    next_mode      = mode;
    next_fstate    = fstate;
    next_q         = q;
    next_rp        = rp;
    next_wp        = wp;
    next_head      = head;
    next_pf_addr   = pf_addr;
    next_drop      = drop;
    next_str_addr  = str_addr;
    next_str_ent   = str_ent;
    next_str_idx   = str_idx;
    next_tag       = tag;
    next_vld       = vld;
    next_cap_act   = cap_act;
    next_cap_ent   = cap_ent;
    next_cap_idx   = cap_idx;
    next_src_store = src_store;
    next_qdata     = qdata;
    next_fetch_ack = 1'b0;
    next_lit_ack   = 1'b0;
    next_lit_data  = lit_data_o;
    next_flash_req = flash_req_o;
    next_flash_addr = flash_addr_o;
    touch_en       = 1'b0;
    touch_ent      = 2'h0;
    push           = 1'b0;
    pop            = 1'b0;
    flush          = 1'b0;
    base           = head;
    store_bus.wr_en   = 1'b0;
    store_bus.wr_addr = {cap_ent, cap_idx};
    store_bus.wr_data = flash_data_i;
    store_bus.rd_addr = {str_ent, str_idx};
    expect_addr = (mode == flash_fetch_pkg::MODE_STORE) ?
                  str_addr : head;
    take = fetch_req_i && !fetch_ack_o;
    free = (fstate == flash_fetch_pkg::FL_IDLE) || flash_ack_i;

    // Flash return: literal goes straight back to the core
    if (flash_ack_i && fstate == flash_fetch_pkg::FL_LIT)
    begin
      next_lit_ack  = 1'b1;
      next_lit_data = flash_data_i;
      next_fstate   = flash_fetch_pkg::FL_IDLE;
    end
    // Flash return: prefetched word enters queue
    if (flash_ack_i && fstate == flash_fetch_pkg::FL_PREF)
    begin
      next_fstate = flash_fetch_pkg::FL_IDLE;
      next_drop   = 1'b0;
      if (!drop)
      begin
        push        = 1'b1;
        next_q[wp]  = flash_data_i;
        next_wp     = 2'(wp + 2'h1);
        if (cap_act)
        begin
          store_bus.wr_en = 1'b1;
          next_cap_idx    = 2'(cap_idx + 2'h1);
          if (cap_idx == flash_fetch_pkg::LAST_WORD)
          begin
            next_vld[cap_ent] = 1'b1;
            next_cap_act      = 1'b0;
          end
        end
      end
    end

    // Core request
    if (take)
    begin
      if (fetch_addr_i == expect_addr)
      begin
        if (mode == flash_fetch_pkg::MODE_STORE)
        begin
          next_fetch_ack = 1'b1;
          next_src_store = 1'b1;
          next_str_addr  = str_addr + flash_fetch_pkg::WORD_STEP;
          next_str_idx   = 2'(str_idx + 2'h1);
          if (str_idx == flash_fetch_pkg::LAST_WORD)
            next_mode = flash_fetch_pkg::MODE_QUEUE;
        end
        else if (cnt != flash_fetch_pkg::CNT_RESET)
        begin
          pop            = 1'b1;
          next_fetch_ack = 1'b1;
          next_src_store = 1'b0;
          next_qdata     = q[rp];
          next_rp        = 2'(rp + 2'h1);
          next_head      = head + flash_fetch_pkg::WORD_STEP;
        end
        // Else the core waits for the queue
      end
      else if (hit_any)
      begin
        // Jump found in the store: answer now
        store_bus.rd_addr = {hit_ent, 2'h0};
        next_fetch_ack = 1'b1;
        next_src_store = 1'b1;
        next_mode      = flash_fetch_pkg::MODE_STORE;
        next_str_ent   = hit_ent;
        next_str_idx   = 2'h1;
        next_str_addr  = fetch_addr_i + flash_fetch_pkg::WORD_STEP;
        flush          = 1'b1;
        base           = fetch_addr_i + flash_fetch_pkg::BURST_SPAN;
        next_cap_act   = 1'b0;
        touch_en  = (hit_ent != 3'(flash_fetch_pkg::IRQ_ENTRY));
        touch_ent = hit_ent[1:0];
      end
      else
      begin
        // Jump missed: refill and learn the target
        next_mode         = flash_fetch_pkg::MODE_QUEUE;
        flush             = 1'b1;
        base              = fetch_addr_i;
        next_cap_act      = 1'b1;
        next_cap_ent      = victim;
        next_cap_idx      = 2'h0;
        next_vld[victim]  = 1'b0;
        next_tag[victim]  = fetch_addr_i;
        touch_en  = (victim != 3'(flash_fetch_pkg::IRQ_ENTRY));
        touch_ent = victim[1:0];
      end
    end

    // Queue fill count
    next_cnt = 3'(cnt + {2'h0, push} - {2'h0, pop});
    if (flush)
    begin
      next_cnt     = flash_fetch_pkg::CNT_RESET;
      next_rp      = 2'h0;
      next_wp      = 2'h0;
      next_head    = base;
      next_pf_addr = base;
      next_drop    = (fstate == flash_fetch_pkg::FL_PREF) &&
                     !flash_ack_i;
    end

    // New flash request; literals first, queue in idle cycles
    if (free)
    begin
      next_flash_req = 1'b0;
      if (lit_req_i && !lit_ack_o &&
          fstate != flash_fetch_pkg::FL_LIT)
      begin
        next_fstate     = flash_fetch_pkg::FL_LIT;
        next_flash_req  = 1'b1;
        next_flash_addr = lit_addr_i;
      end
      else if (next_cnt < flash_fetch_pkg::QUEUE_FULL)
      begin
        next_fstate     = flash_fetch_pkg::FL_PREF;
        next_flash_req  = 1'b1;
        next_flash_addr = next_pf_addr;
        next_pf_addr    = next_pf_addr + flash_fetch_pkg::WORD_STEP;
      end
    end
  end

  // =========================================================
  // Registers
  // =========================================================
  // Holds all fetch state; entries start invalid
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode      <= flash_fetch_pkg::MODE_QUEUE;
      fstate    <= flash_fetch_pkg::FL_IDLE;
      for (int i = 0; i < flash_fetch_pkg::QUEUE_DEPTH; i++)
        q[i] <= '0;
      rp        <= 2'h0;
      wp        <= 2'h0;
      cnt       <= flash_fetch_pkg::CNT_RESET;
      head      <= flash_fetch_pkg::ADDR_RESET;
      pf_addr   <= flash_fetch_pkg::ADDR_RESET;
      drop      <= 1'b0;
      str_addr  <= flash_fetch_pkg::ADDR_RESET;
      str_ent   <= 3'h0;
      str_idx   <= 2'h0;
      for (int e = 0; e < flash_fetch_pkg::ALL_ENTRIES; e++)
        tag[e] <= flash_fetch_pkg::ADDR_RESET;
      vld       <= 5'h00;
      for (int i = 0; i < flash_fetch_pkg::GEN_ENTRIES; i++)
        age[i] <= 2'(i);
      cap_act   <= 1'b0;
      cap_ent   <= 3'h0;
      cap_idx   <= 2'h0;
      src_store <= 1'b0;
      qdata     <= '0;
      fetch_ack_o  <= 1'b0;
      lit_ack_o    <= 1'b0;
      lit_data_o   <= '0;
      flash_req_o  <= 1'b0;
      flash_addr_o <= flash_fetch_pkg::ADDR_RESET;
    end
    else
    begin
      mode      <= next_mode;
      fstate    <= next_fstate;
      q         <= next_q;
      rp        <= next_rp;
      wp        <= next_wp;
      cnt       <= next_cnt;
      head      <= next_head;
      pf_addr   <= next_pf_addr;
      drop      <= next_drop;
      str_addr  <= next_str_addr;
      str_ent   <= next_str_ent;
      str_idx   <= next_str_idx;
      tag       <= next_tag;
      vld       <= next_vld;
      age       <= next_age;
      cap_act   <= next_cap_act;
      cap_ent   <= next_cap_ent;
      cap_idx   <= next_cap_idx;
      src_store <= next_src_store;
      qdata     <= next_qdata;
      fetch_ack_o  <= next_fetch_ack;
      lit_ack_o    <= next_lit_ack;
      lit_data_o   <= next_lit_data;
      flash_req_o  <= next_flash_req;
      flash_addr_o <= next_flash_addr;
    end
  end

  // Answer word: both sources are registers
  assign fetch_data_o = src_store ? store_bus.rd_data : qdata;

endmodule

// file: sim/flash_fetch_assertions.sv
// Port checker for the flash fetch front end, bound to its top module
module flash_fetch_checker (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        fetch_req_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic        fetch_ack_o,
  input wire logic [31:0] fetch_data_o,
  input wire logic        lit_req_i,
  input wire logic [31:0] lit_addr_i,
  input wire logic        lit_ack_o,
  input wire logic [31:0] lit_data_o,
  input wire logic        flash_req_o,
  input wire logic [31:0] flash_addr_o,
  input wire logic        flash_ack_i,
  input wire logic [31:0] flash_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idle_acks; // Flash words landed while the core is quiet
  // =========================================================
  // Idle prefetch counter
  // =========================================================
  // Cleared by any core or literal request, saturates at 7
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      idle_acks <= 3'h0;
    else if (fetch_req_i || lit_req_i)
      idle_acks <= 3'h0;
    else if (flash_ack_i && idle_acks != 3'h7)
      idle_acks <= idle_acks + 3'h1;
  // =========================================================
  // Assertions
  // =========================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  flash_hold_a: assert property (
    flash_req_o && !flash_ack_i |=> flash_req_o && $stable(flash_addr_o))
    else $error("flash request dropped or moved before its answer");
  lit_timing_a: assert property (lit_ack_o |-> $past(flash_ack_i))
    else $error("literal answer without a flash answer before it");
  lit_data_a: assert property (
    lit_ack_o |-> lit_data_o == $past(flash_data_i))
    else $error("literal word differs from the flash word");
  ack_pulse_a: assert property (fetch_ack_o |=> !fetch_ack_o)
    else $error("fetch answer longer than one cycle");
  reset_pref_a: assert property (
    $rose(rstn_i) |=> flash_req_o && flash_addr_o == 32'h00000000)
    else $error("no prefetch from zero after reset");
  lit_issue_a: assert property (
    lit_req_i && !lit_ack_o && (!flash_req_o || flash_ack_i) &&
    !(flash_req_o && flash_addr_o == lit_addr_i)
    |=> flash_req_o && flash_addr_o == $past(lit_addr_i))
    else $error("literal read not issued when flash was free");
  fetch_bound_a: assert property (
    $rose(fetch_req_i) |-> ##[1:60] fetch_ack_o)
    else $error("fetch never answered");
  idle_limit_a: assert property (idle_acks <= 3'h5)
    else $error("prefetch ran past the queue depth");
  // Main scenarios
  cov_fast: cover property ($rose(fetch_req_i) ##1 fetch_ack_o);
  cov_lit: cover property (lit_ack_o);
  cov_slow: cover property (flash_req_o && !flash_ack_i [*3]);
endmodule
bind flash_prefetch_branch_cache flash_fetch_checker u_flash_fetch_checker (
  .clk_sys_i, .rstn_i, .fetch_req_i, .fetch_addr_i, .fetch_ack_o,
  .fetch_data_o, .lit_req_i, .lit_addr_i, .lit_ack_o, .lit_data_o,
  .flash_req_o, .flash_addr_o, .flash_ack_i, .flash_data_i);

// file: sim/flash_model.sv
// Behavioural burst flash answering one word per read
module flash_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  lat_i,
  output logic             ack_o,
  output logic [31:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt; // Cycles waited on the current read
  // =========================================================
  // Read answer
  // =========================================================
  // Word is a pattern of its address; bus inverts when not valid
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
    begin
      ack_o    <= 1'b0;
      data_o   <= 32'h00000000;
      wait_cnt <= 4'h0;
    end
    else
    begin
      ack_o  <= 1'b0;
      data_o <= ~data_o;
      if (req_i && !ack_o)
        if (wait_cnt >= lat_i)
        begin
          ack_o    <= 1'b1; // One 32-bit word per read
          data_o   <= {~addr_i[15:0], addr_i[15:0]};
          wait_cnt <= 4'h0;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
    end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the flash fetch front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Vector-read address; value is arbitrary
  localparam logic [31:0] IRQ_ADDR = 32'h00000c40;
  logic        clk_sys_i, rstn_i, fetch_req_i, fetch_ack_o;
  logic        lit_req_i, lit_ack_o, flash_req_o, flash_ack_i;
  logic [31:0] fetch_addr_i, fetch_data_o, lit_addr_i, lit_data_o;
  logic [31:0] flash_addr_o, flash_data_i;
  logic [31:0] n_fack = 32'h0; // Flash answers seen, one driver only
  logic [3:0]  lat;
  int          n_fail, n_tests, c;
  // =========================================================
  // Design and flash
  // =========================================================
  flash_prefetch_branch_cache #(.IRQ_VEC_ADDR(IRQ_ADDR))
    u_flash_prefetch_branch_cache (
    .clk_sys_i, .rstn_i, .fetch_req_i, .fetch_addr_i, .fetch_ack_o,
    .fetch_data_o, .lit_req_i, .lit_addr_i, .lit_ack_o, .lit_data_o,
    .flash_req_o, .flash_addr_o, .flash_ack_i, .flash_data_i);
  flash_model u_flash_model (
    .clk_sys_i, .rstn_i, .req_i(flash_req_o), .addr_i(flash_addr_o),
    .lat_i(lat), .ack_o(flash_ack_i), .data_o(flash_data_i));
  // =========================================================
  // Clock and flash word counter
  // =========================================================
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    if (flash_ack_i === 1'b1)
      n_fack <= n_fack + 32'h1;
  // =========================================================
  // Helpers
  // =========================================================
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One core fetch; cyc counts edges up to the one that sees the answer
  // Request held through that edge, word taken there, then released
  task automatic fetch(input logic [31:0] a, output int cyc);
    @(posedge clk_sys_i);
    #1;
    fetch_req_i  = 1'b1;
    fetch_addr_i = a;
    cyc = 0;
    do
    begin
      @(posedge clk_sys_i);
      cyc++;
    end while (fetch_ack_o !== 1'b1 && cyc < 200);
    chk({31'h0, fetch_ack_o}, 32'h1);
    chk(fetch_data_o, pat(a));
    #1;
    fetch_req_i = 1'b0;
  endtask
  // One literal read
  task automatic lit(input logic [31:0] a);
    int n;
    @(posedge clk_sys_i);
    #1;
    lit_req_i  = 1'b1;
    lit_addr_i = a;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end while (lit_ack_o !== 1'b1 && n < 200);
    chk({31'h0, lit_ack_o}, 32'h1);
    chk(lit_data_o, pat(a));
    #1;
    lit_req_i = 1'b0;
  endtask
  task automatic run4(input logic [31:0] b);
    for (int i = 0; i < 4; i++)
      fetch(b + 32'(4 * i), c);
  endtask
  task automatic fast(input logic [31:0] a);
    fetch(a, c);
    chk(32'(c), 32'h2);
  endtask
  task automatic slow(input logic [31:0] a);
    fetch(a, c);
    chk(32'(c > 4), 32'h1);
  endtask
  // =========================================================
  // Scenarios
  // =========================================================
  task automatic t_fill;
    repeat (40) @(posedge clk_sys_i);
    #1;
    chk(n_fack, 32'h4);
    chk({31'h0, flash_req_o}, 32'h0);
  endtask
  task automatic t_seq;
    for (int i = 0; i < 8; i++)
      fetch(32'(4 * i), c);
    repeat (20) @(posedge clk_sys_i);
    fetch(32'h00000020, c);
    chk(32'(c), 32'h2);
  endtask
  task automatic t_miss_hit;
    lat = 4'h3;
    slow(32'h00000200);
    for (int i = 1; i < 4; i++)
      fetch(32'h00000200 + 32'(4 * i), c);
    slow(32'h00000400);
    for (int i = 1; i < 4; i++)
      fetch(32'h00000400 + 32'(4 * i), c);
    for (int i = 0; i < 4; i++)
      fast(32'h00000200 + 32'(4 * i));
    fetch(32'h00000210, c);
  endtask
  task automatic t_lru;
    logic [31:0] hits [4];
    hits = '{32'h00000200, 32'h00000600, 32'h00000800, 32'h00000a00};
    run4(32'h00000600);
    run4(32'h00000800);
    run4(32'h00000a00);
    foreach (hits[i])
      fast(hits[i]);
    slow(32'h00000400);
  endtask
  task automatic t_irq;
    run4(IRQ_ADDR);
    for (int k = 0; k < 5; k++)
      run4(32'h00001000 + 32'(k * 256));
    fast(IRQ_ADDR);
  endtask
  task automatic t_lit;
    lat = 4'h2;
    fetch(32'h00002000, c);
    fetch(32'h00002004, c);
    repeat (20) @(posedge clk_sys_i);
    lit(32'h00008000);
    fast(32'h00002008);
    lit(32'h00008100);
    fast(32'h0000200c);
  endtask
  // =========================================================
  // Verdict and main sequence
  // =========================================================
  task automatic results;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    rstn_i       = 1'b0;
    fetch_req_i  = 1'b0;
    fetch_addr_i = 32'h00000000;
    lit_req_i    = 1'b0;
    lit_addr_i   = 32'h00000000;
    lat          = 4'h0;
    n_fail       = 0;
    n_tests      = 0;
    repeat (20) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    t_fill();
    t_seq();
    t_miss_hit();
    t_lru();
    t_irq();
    t_lit();
    results();
  end
  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    results();
  end
endmodule
